// File: logic/rcfg_defines.svh
`ifndef RCFG_DEFINES_SVH
`define RCFG_DEFINES_SVH

// Register offsets on the serial host register port.
`define RCFG_ADDR_CH2_CONTROL      8'h2e
`define RCFG_ADDR_CH0_ALT_VOLTAGE  8'h2f
`define RCFG_ADDR_LINEAR_VOLTAGE   8'h38

// Reset values; the other two registers load factory values at reset.
`define RCFG_CH0_ALT_RESET         8'h14

// Channel 2 control field positions.
`define RCFG_MODE_HI               7
`define RCFG_MODE_LO               6
`define RCFG_IPEAK_HI              5
`define RCFG_IPEAK_LO              4
`define RCFG_DISCHARGE_BIT         3
`define RCFG_ENABLE_HI             2
`define RCFG_ENABLE_LO             0
`define RCFG_FORCE_BIT             2
`define RCFG_FORCE_ON_BIT          1

// Linear regulator field positions.
`define RCFG_LIN_OFFSET_BIT        7
`define RCFG_LIN_CODE_HI           6

// Peak current limits in mA.
`define RCFG_IPEAK_CODE0_MA        10'h3e8
`define RCFG_IPEAK_CODE1_MA        10'h2ee
`define RCFG_IPEAK_CODE2_MA        10'h1f4
`define RCFG_IPEAK_CODE3_MA        10'h14d

// Voltage transfer function in mV.
`define RCFG_VOUT_BASE_MV          13'h01f4
`define RCFG_VOUT_STEP_MV          13'h0019
`define RCFG_VOUT_MAX_MV           13'h157c
`define RCFG_VOUT_CLAMP_CODE       8'hc8
`define RCFG_LIN_OFFSET_MV         13'h052d

`endif

// File: logic/rcfg_pkg.sv
package rcfg_pkg;
  typedef enum logic [1:0] {
    RCFG_MODE_AUTO       = 2'h0,
    RCFG_MODE_BUCK       = 2'h1,
    RCFG_MODE_BOOST      = 2'h2,
    RCFG_MODE_BUCK_BOOST = 2'h3
  } rcfg_mode_e;

  typedef logic [12:0] rcfg_mv_t;
endpackage

// File: logic/rcfg_mv_decode.sv
`timescale 1ns/1ps
`include "rcfg_defines.svh"

module rcfg_mv_decode (
  input  wire logic             clock,      // System clock.
  input  wire logic             rst,        // Synchronous reset, active high.
  input  wire logic [7:0]       code,       // Target voltage code.
  input  wire logic             clamp_en,   // Saturate codes at and above the clamp code.
  input  wire logic             offset_en,  // Add the fixed offset voltage.
  output rcfg_pkg::rcfg_mv_t    mv_reg      // Decoded target voltage in mV.
);
  wire logic [20:0]          step_sum = 21'(code) * 21'(`RCFG_VOUT_STEP_MV);
  wire rcfg_pkg::rcfg_mv_t   linear_mv = 13'(step_sum) + `RCFG_VOUT_BASE_MV;
  wire logic                 clamped   = clamp_en && (code >= `RCFG_VOUT_CLAMP_CODE);
  wire rcfg_pkg::rcfg_mv_t   ofs_mv    = offset_en ? `RCFG_LIN_OFFSET_MV : 13'h0000;
  wire rcfg_pkg::rcfg_mv_t   mv_next   = clamped ? `RCFG_VOUT_MAX_MV : linear_mv + ofs_mv;

  always_ff @(posedge clock) begin
    if (rst) begin
      mv_reg <= `RCFG_VOUT_BASE_MV;
    end else begin
      mv_reg <= mv_next;
    end
  end
endmodule

// File: logic/rcfg_regs.sv
// What this block does
// - Channel 2 mode bits 7:6 pick automatic, buck, boost or buck-boost.
// - Channel 2 peak limit bits 5:4 pick 1.000, 0.750, 0.500 or 0.333 A.
// - Channel 2 discharge bit 3 applies the discharge resistor while channel is off.
// - Enable codes 0 to 3 place channel 2 in sequencer slot 0 to 3.
// - Enable codes 4 and 5 force channel off; 6 and 7 force it on.
// - Channel 0 alternate voltage resets 0x14, 0.5 V plus 25 mV steps, clamps 5.5 V.
// - Linear regulator seven-bit code gives 0.5 V plus 25 mV steps up to 3.675 V.
// - Linear regulator offset bit adds 1.325 V to the selected target.
`timescale 1ns/1ps
`include "rcfg_defines.svh"

module rcfg_regs (
  input  wire logic             clock,                          // System clock, 100 MHz.
  input  wire logic             rst,                            // Synchronous reset, active high.
  input  wire logic [7:0]       otp_ch2_control,                // Factory value for channel 2 control.
  input  wire logic [7:0]       otp_linear_voltage,             // Factory value for linear regulator voltage.
  input  wire logic [7:0]       reg_addr,                       // Register address from host interface.
  input  wire logic [7:0]       reg_wdata,                      // Write data.
  input  wire logic             reg_write,                      // Write strobe, one cycle.
  input  wire logic             reg_read,                       // Read strobe, one cycle.
  input  wire logic [3:0]       power_sequencer_slot_on,        // Sequencer slot active levels.
  output logic [7:0]            reg_rdata_reg,                  // Read data.
  output logic                  reg_rack_reg,                   // Read answer pulse.
  output rcfg_pkg::rcfg_mode_e  conversion_mode_select_reg,     // Channel 2 conversion mode.
  output logic [9:0]            ch2_peak_current_limit_ma_reg,  // Channel 2 peak current in mA.
  output logic [1:0]            power_sequencer_slot_reg,       // Channel 2 sequencer slot.
  output logic                  ch2_on_reg,                     // Channel 2 regulator enabled.
  output logic                  ch2_discharge_active_reg,       // Channel 2 discharge resistor on.
  output rcfg_pkg::rcfg_mv_t    ch0_alt_target_mv_reg,          // Channel 0 alternate target, mV.
  output rcfg_pkg::rcfg_mv_t    linear_reg_target_mv_reg        // Linear regulator target, mV.
);
  logic [7:0] ch2_control_reg;
  logic [7:0] ch0_alt_target_voltage_reg;
  logic [7:0] linear_voltage_reg;

  wire logic hit_ch2 = reg_addr == `RCFG_ADDR_CH2_CONTROL;
  wire logic hit_ch0 = reg_addr == `RCFG_ADDR_CH0_ALT_VOLTAGE;
  wire logic hit_lin = reg_addr == `RCFG_ADDR_LINEAR_VOLTAGE;

  // Unmapped addresses read as zero and ignore writes.
  wire logic [7:0] rdata_next = hit_ch2 ? ch2_control_reg :
                                hit_ch0 ? ch0_alt_target_voltage_reg :
                                hit_lin ? linear_voltage_reg : 8'h00;

  wire logic [1:0] mode_field    = ch2_control_reg[`RCFG_MODE_HI:`RCFG_MODE_LO];
  wire logic [1:0] ipeak_field   = ch2_control_reg[`RCFG_IPEAK_HI:`RCFG_IPEAK_LO];
  wire logic       ch2_discharge_enable = ch2_control_reg[`RCFG_DISCHARGE_BIT];
  wire logic [2:0] ch2_enable_select    = ch2_control_reg[`RCFG_ENABLE_HI:`RCFG_ENABLE_LO];

  wire logic       forced   = ch2_enable_select[`RCFG_FORCE_BIT];
  wire logic [1:0] slot     = ch2_enable_select[1:0];
  wire logic       on_next  = forced ? ch2_enable_select[`RCFG_FORCE_ON_BIT]
                                     : power_sequencer_slot_on[slot];
  wire logic       dis_next = ch2_discharge_enable && !on_next;

  wire logic [9:0] ipeak_next = (ipeak_field == 2'h0) ? `RCFG_IPEAK_CODE0_MA :
                                (ipeak_field == 2'h1) ? `RCFG_IPEAK_CODE1_MA :
                                (ipeak_field == 2'h2) ? `RCFG_IPEAK_CODE2_MA :
                                                        `RCFG_IPEAK_CODE3_MA;

  // Factory values are loaded while reset is held, so they must be stable then.
  always_ff @(posedge clock) begin
    if (rst) begin
      ch2_control_reg            <= otp_ch2_control;
      ch0_alt_target_voltage_reg <= `RCFG_CH0_ALT_RESET;
      linear_voltage_reg         <= otp_linear_voltage;
    end else if (reg_write) begin
      if (hit_ch2) begin
        ch2_control_reg <= reg_wdata;
      end
      if (hit_ch0) begin
        ch0_alt_target_voltage_reg <= reg_wdata;
      end
      if (hit_lin) begin
        linear_voltage_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
      reg_rack_reg  <= 1'b0;
    end else begin
      reg_rdata_reg <= reg_read ? rdata_next : reg_rdata_reg;
      reg_rack_reg  <= reg_read;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conversion_mode_select_reg    <= rcfg_pkg::RCFG_MODE_AUTO;
      ch2_peak_current_limit_ma_reg <= `RCFG_IPEAK_CODE0_MA;
      power_sequencer_slot_reg      <= 2'h0;
      ch2_on_reg                    <= 1'b0;
      ch2_discharge_active_reg      <= 1'b0;
    end else begin
      conversion_mode_select_reg    <= rcfg_pkg::rcfg_mode_e'(mode_field);
      ch2_peak_current_limit_ma_reg <= ipeak_next;
      power_sequencer_slot_reg      <= slot;
      ch2_on_reg                    <= on_next;
      ch2_discharge_active_reg      <= dis_next;
    end
  end

  // Channel 0 code saturates at 5.5 V; the linear code carries the offset bit instead.
  rcfg_mv_decode u_ch0_dec (
    .clock     (clock),
    .rst       (rst),
    .code      (ch0_alt_target_voltage_reg),
    .clamp_en  (1'b1),
    .offset_en (1'b0),
    .mv_reg    (ch0_alt_target_mv_reg)
  );

  rcfg_mv_decode u_lin_dec (
    .clock     (clock),
    .rst       (rst),
    .code      ({1'b0, linear_voltage_reg[`RCFG_LIN_CODE_HI:0]}),
    .clamp_en  (1'b0),
    .offset_en (linear_voltage_reg[`RCFG_LIN_OFFSET_BIT]),
    .mv_reg    (linear_reg_target_mv_reg)
  );
endmodule

// File: sim/rcfg_regs_asserts.sv
`timescale 1ns/1ps
module rcfg_regs_chk (
  input wire logic                 clock,                          // Clock.
  input wire logic                 rst,                            // Reset.
  input wire logic [7:0]           reg_addr,                       // Address.
  input wire logic [7:0]           reg_wdata,                      // Write data.
  input wire logic                 reg_write,                      // Write strobe.
  input wire logic                 reg_read,                       // Read strobe.
  input wire logic                 reg_rack_reg,                   // Read answer.
  input wire rcfg_pkg::rcfg_mode_e conversion_mode_select_reg,     // Mode.
  input wire logic [9:0]           ch2_peak_current_limit_ma_reg,  // Peak current.
  input wire logic [1:0]           power_sequencer_slot_reg,       // Slot.
  input wire logic                 ch2_on_reg,                     // Channel on.
  input wire logic                 ch2_discharge_active_reg,       // Discharge.
  input wire rcfg_pkg::rcfg_mv_t   ch0_alt_target_mv_reg,          // Alt target.
  input wire rcfg_pkg::rcfg_mv_t   linear_reg_target_mv_reg        // Linear target.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence ch2_wr;
    reg_write && reg_addr == 8'h2e;
  endsequence
  mode_sel_a: assert property (ch2_wr |=> ##1 conversion_mode_select_reg == $past(reg_wdata[7:6], 2))
    else $error("mode mismatch");
  peak_limit_a: assert property (ch2_wr ##0 reg_wdata[5:4] == 2'h3 |=> ##1 ch2_peak_current_limit_ma_reg == 10'h14d)
    else $error("peak mismatch");
  discharge_a: assert property (ch2_wr |=> ##1 ch2_discharge_active_reg == ($past(reg_wdata[3], 2) && !ch2_on_reg))
    else $error("discharge mismatch");
  slot_sel_a: assert property (ch2_wr ##0 !reg_wdata[2] |=> ##1 power_sequencer_slot_reg == $past(reg_wdata[1:0], 2))
    else $error("slot mismatch");
  force_on_off_a: assert property (ch2_wr ##0 reg_wdata[2] |=> ##1 ch2_on_reg == $past(reg_wdata[1], 2))
    else $error("force mismatch");
  alt_reset_a: assert property ($fell(rst) |=> ch0_alt_target_mv_reg == 13'h03e8)
    else $error("alt reset mismatch");
  alt_volt_a: assert property (reg_write && reg_addr == 8'h2f |=> ##1 ch0_alt_target_mv_reg == ($past(reg_wdata, 2) >= 8'hc8 ? 13'h157c : 13'h01f4 + 13'($past(reg_wdata, 2)) * 13'h0019))
    else $error("alt voltage mismatch");
  lin_volt_a: assert property (reg_write && reg_addr == 8'h38 |=> ##1 linear_reg_target_mv_reg == 13'h01f4 + 13'($past(reg_wdata[6:0], 2)) * 13'h0019 + ($past(reg_wdata[7], 2) ? 13'h052d : 13'h0000))
    else $error("linear voltage mismatch");
  read_ack_a: assert property (reg_read |=> reg_rack_reg)
    else $error("read answer missing");
endmodule
bind rcfg_regs rcfg_regs_chk chk_i (.*);

// File: sim/rcfg_host_model.sv
`timescale 1ns/1ps
module rcfg_host_model (
  input  wire logic       clock,          // Clock.
  input  wire logic [7:0] reg_rdata_reg,  // Read data.
  input  wire logic       reg_rack_reg,   // Read answer.
  output logic [7:0]      reg_addr,       // Address.
  output logic [7:0]      reg_wdata,      // Write data.
  output logic            reg_write,      // Write strobe.
  output logic            reg_read        // Read strobe.
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Bias low-power select lives outside this bank, so this host never touches it.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q, output logic k);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_write = w;
    reg_read = !w;
    @(negedge clock);
    q = reg_rdata_reg;
    k = reg_rack_reg;
    reg_write = 1'b0;
    reg_read = 1'b0;
    // Released qualifiers flip so a design that samples them late sees garbage.
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock, rst, wr, rd, rack, on, disch, k;
  logic [3:0] slot_on;
  logic [7:0] addr, wdata, rdata, d;
  logic [9:0] ipeak;
  logic [1:0] slot;
  rcfg_pkg::rcfg_mode_e mode;
  rcfg_pkg::rcfg_mv_t alt_mv, lin_mv;
  int n_errors, check_count;
  logic [9:0] ma [4] = '{10'h3e8, 10'h2ee, 10'h1f4, 10'h14d};
  logic [7:0] codes [5] = '{8'h00, 8'h7f, 8'hc7, 8'hc8, 8'hff};
  rcfg_host_model rcfg_host_model_i (.clock(clock), .reg_rdata_reg(rdata), .reg_rack_reg(rack), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr), .reg_read(rd));
  rcfg_regs rcfg_regs_i (.clock(clock), .rst(rst), .otp_ch2_control(8'h5a), .otp_linear_voltage(8'ha5),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .power_sequencer_slot_on(slot_on),
    .reg_rdata_reg(rdata), .reg_rack_reg(rack), .conversion_mode_select_reg(mode),
    .ch2_peak_current_limit_ma_reg(ipeak), .power_sequencer_slot_reg(slot), .ch2_on_reg(on),
    .ch2_discharge_active_reg(disch), .ch0_alt_target_mv_reg(alt_mv), .linear_reg_target_mv_reg(lin_mv));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    rcfg_host_model_i.access(1'b1, a, v, d, k);
    @(negedge clock);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    rcfg_host_model_i.access(1'b0, a, 8'h00, d, k);
    chk(k, 1'b1);
    chk(d, e);
  endtask
  task automatic t_reset;
    rd8(8'h2f, 8'h14);
    chk(alt_mv, 13'h03e8);
    rd8(8'h2e, 8'h5a);
    rd8(8'h38, 8'ha5);
    chk(mode, 2'h1);
    chk(ipeak, 10'h2ee);
    chk(slot, 2'h2);
    chk(on, 1'b1);
    chk(disch, 1'b0);
    chk(lin_mv, 13'h0abe);
  endtask
  task automatic t_ch2;
    for (int i = 0; i < 8; i++) begin
      logic e;
      e = i[2] ? i[1] : slot_on[i[1:0]];
      wr8(8'h2e, {i[1:0], i[1:0], 1'b1, i[2:0]});
      chk(mode, i[1:0]);
      chk(ipeak, ma[i[1:0]]);
      chk(on, e);
      chk(disch, !e);
      chk(slot, i[1:0]);
      rd8(8'h2e, {i[1:0], i[1:0], 1'b1, i[2:0]});
    end
    wr8(8'h2e, 8'h04);
    chk(disch, 1'b0);
    // The slot levels are live inputs, so the channel must follow them without a new write.
    wr8(8'h2e, 8'h09);
    chk(on, 1'b0);
    chk(disch, 1'b1);
    slot_on = 4'b0111;
    @(negedge clock);
    chk(on, 1'b1);
    chk(disch, 1'b0);
    slot_on = 4'b0101;
  endtask
  task automatic t_rerun;
    wr8(8'h2f, 8'h40);
    chk(alt_mv, 13'h0834);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    chk(alt_mv, 13'h01f4);
    chk(rack, 1'b0);
    rst = 1'b0;
    rd8(8'h2f, 8'h14);
    chk(alt_mv, 13'h03e8);
  endtask
  task automatic t_volt;
    foreach (codes[j]) begin
      wr8(8'h2f, codes[j]);
      chk(alt_mv, codes[j] >= 8'hc8 ? 13'h157c : 13'h01f4 + 13'(codes[j]) * 13'h0019);
      wr8(8'h38, codes[j]);
      chk(lin_mv, 13'h01f4 + 13'(codes[j][6:0]) * 13'h0019 + (codes[j][7] ? 13'h052d : 13'h0000));
    end
    wr8(8'h30, 8'h33);
    rd8(8'h30, 8'h00);
    rd8(8'h2f, 8'hff);
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    slot_on = 4'b0101;
    n_errors = 0;
    check_count = 0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    t_reset;
    t_ch2;
    t_volt;
    t_rerun;
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    end_of_test;
  end
endmodule
